// file: include/cpw_pkg.sv
// Overview of operation
// RULE1: full ten-bit duty resolution is reached only when the period limit holds 255.
// RULE2: the number of distinct duty settings is four times the period limit plus one.
// RULE3: a duty value beyond the period never matches, so the output keeps its level.
// RULE4: while asleep the period timer stops and no state of the unit changes.
// RULE5: an output being driven when sleep begins keeps its level through sleep.
// RULE6: after wake the period timer continues from the value it held.
// RULE7: the time base runs from the system clock, so its rate scales the pwm frequency.
// RULE8: any reset puts the pin to input direction and all registers to reset values.
// RULE9: mode 0000 is off and resets the unit, 0001 and 0011 are reserved, 11xx is pwm.
// RULE10: in pwm mode control bits 5-4 hold the two low duty bits, the high byte the rest.
// RULE11: capture modes 0100 to 0111 capture on falling, rising, 4th and 16th rising edges.
// RULE12: compare modes toggle, set with flag, clear, interrupt only, or fire a trigger.
// RULE13: the period timer prescaler divides by 1, 4 or 16.
// RULE14: the step after timer equals period clears it, sets the pin unless duty 0, latches duty.
// RULE15: the pin clears when the ten-bit time base equals the latched duty value.
// RULE16: duty writes reach the active latch only at period end; the latch is read-only in pwm.
// RULE17: duty compare is unsigned and a zero duty keeps the output low.
package cpw_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADR_MODE = 4'h0;
    localparam logic [3:0] ADR_DUTY = 4'h1;
    localparam logic [3:0] ADR_LATCH = 4'h2;
    localparam logic [3:0] ADR_PERIOD = 4'h3;
    localparam logic [3:0] ADR_TCFG = 4'h4;
    localparam logic [3:0] ADR_TCNT = 4'h5;
    localparam logic [3:0] ADR_CMPH = 4'h6;
    localparam logic [3:0] ADR_DIR = 4'h7;
    localparam logic [3:0] ADR_IST = 4'h8;
    localparam logic [3:0] ADR_IMSK = 4'h9;
    // ------------------------------------------------------------
    // reset values and fields
    // ------------------------------------------------------------
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_PERIOD = 8'hFF;
    localparam logic [7:0] RST_TCFG = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam int TCFG_RUN = 2;
    localparam int IRQ_EVT = 0;
    localparam int IRQ_PER = 1;
    localparam int IRQ_TRIG = 2;
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV4 = 2'h1;
    localparam logic [3:0] M_OFF = 4'h0;
    localparam logic [3:0] M_TOG = 4'h2;
    localparam logic [3:0] M_CFALL = 4'h4;
    localparam logic [3:0] M_CRISE = 4'h5;
    localparam logic [3:0] M_CR4 = 4'h6;
    localparam logic [3:0] M_CR16 = 4'h7;
    localparam logic [3:0] M_CSET = 4'h8;
    localparam logic [3:0] M_CCLR = 4'h9;
    localparam logic [3:0] M_CSWI = 4'hA;
    localparam logic [3:0] M_CTRG = 4'hB;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cpw_bus_req_t;
endpackage

// file: src/cpw_unit.sv
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
module cpw_unit (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire cpw_pkg::cpw_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic cap_pin_in,
    input wire logic [15:0] ext_timer_val,
    output logic pin_out,
    output logic pin_oe_n,
    output logic special_trigger,
    output logic irq
);
    import cpw_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] mode_ff, duty_ff, latch_ff, period_ff, tcfg_ff, tcnt_ff, cmph_ff;
    logic [7:0] ist_ff, imsk_ff, rdata_ff;
    logic dir_ff, out_ff, trig_ff;
    logic [1:0] lat_lo_ff;
    logic [5:0] pre_ff;
    logic [3:0] cap_cnt_ff;
    logic cap_s1_ff, cap_s2_ff, cap_prev_ff;
    logic [7:0] cap_lo_ff;

    logic [3:0] msel;
    logic pwm_mode, tick, period_match, base_match, cap_evt, cmp_evt;
    logic [9:0] time_base;
    logic [7:0] nxt_ist;

    // clk_en low is sleep: every process below is gated by it RULE4
    assign msel = mode_ff[3:0];
    assign pwm_mode = (msel[3:2] == 2'b11); // RULE9

    // last clock of one timer step: 4, 16 or 64 system clocks RULE13
    function automatic logic [5:0] pre_limit(input logic [1:0] sel);
        case (sel)
            PS_DIV1: pre_limit = 6'h03;
            PS_DIV4: pre_limit = 6'h0F;
            default: pre_limit = 6'h3F;
        endcase
    endfunction

    // a step ends at the limit; >= also recovers when the prescale drops RULE13 RULE7
    logic step;
    assign step = tcfg_ff[TCFG_RUN] && (pre_ff >= pre_limit(tcfg_ff[1:0]));
    assign period_match = step && (tcnt_ff == period_ff); // RULE14

    // low two bits: clock phase at 1:1, else the top prescaler bits RULE15
    always_comb begin
        case (tcfg_ff[1:0])
            PS_DIV1: begin
                time_base = {tcnt_ff, pre_ff[1:0]};
                tick = 1'b1;
            end
            PS_DIV4: begin
                time_base = {tcnt_ff, pre_ff[3:2]};
                tick = (pre_ff[1:0] == 2'h3);
            end
            default: begin
                time_base = {tcnt_ff, pre_ff[5:4]};
                tick = (pre_ff[3:0] == 4'hF);
            end
        endcase
    end

    // the pin register lags a clock, so clear on the last clock before the base hits the duty
    // unsigned compare; duty past the period never matches
    assign base_match = tcfg_ff[TCFG_RUN] && tick
        && (time_base + 10'h001 == {latch_ff, lat_lo_ff}); // RULE15 RULE3 RULE17

    // prescaler counts system clocks within one timer step
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pre_ff <= 6'h00;
        end else if (clk_en) begin
            if (!tcfg_ff[TCFG_RUN] || step) begin
                pre_ff <= 6'h00;
            end else begin
                pre_ff <= pre_ff + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // period timer: holds its count across sleep RULE6
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tcnt_ff <= RST_ZERO; // RULE8
        end else if (clk_en) begin
            if (bus_req.wr && bus_req.addr == ADR_TCNT) begin
                tcnt_ff <= bus_req.wdata;
            end else if (step && tcnt_ff == period_ff) begin
                tcnt_ff <= RST_ZERO; // RULE14 RULE1 RULE2
            end else if (step) begin
                tcnt_ff <= tcnt_ff + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_ff <= RST_MODE; // RULE8
            duty_ff <= RST_ZERO;
            period_ff <= RST_PERIOD;
            tcfg_ff <= RST_TCFG;
            cmph_ff <= RST_ZERO;
            dir_ff <= 1'b1;
            imsk_ff <= RST_ZERO;
        end else if (clk_en && bus_req.wr) begin
            case (bus_req.addr)
                ADR_MODE: mode_ff <= {2'b00, bus_req.wdata[5:0]}; // RULE10
                ADR_DUTY: duty_ff <= bus_req.wdata; // RULE16
                ADR_PERIOD: period_ff <= bus_req.wdata;
                ADR_TCFG: tcfg_ff <= {1'b0, bus_req.wdata[6:0]};
                ADR_CMPH: cmph_ff <= bus_req.wdata;
                ADR_DIR: dir_ff <= bus_req.wdata[0];
                ADR_IMSK: imsk_ff <= {5'h00, bus_req.wdata[2:0]};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // active duty latch and capture register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || (clk_en && msel == M_OFF)) begin
            latch_ff <= RST_ZERO; // RULE9
            lat_lo_ff <= 2'h0;
            cap_lo_ff <= RST_ZERO;
        end else if (clk_en) begin
            if (pwm_mode) begin
                if (step && tcnt_ff == period_ff) begin
                    latch_ff <= duty_ff; // RULE16
                    lat_lo_ff <= mode_ff[5:4]; // RULE10
                end
            end else if (cap_evt) begin
                latch_ff <= ext_timer_val[15:8];
                cap_lo_ff <= ext_timer_val[7:0];
            end else if (bus_req.wr && bus_req.addr == ADR_LATCH) begin
                latch_ff <= bus_req.wdata; // writable outside pwm only RULE16
            end
        end
    end

    // ------------------------------------------------------------
    // capture input: two-flop sync, then edge detect RULE11
    // ------------------------------------------------------------
    logic rise, fall;
    assign rise = cap_s2_ff && !cap_prev_ff;
    assign fall = !cap_s2_ff && cap_prev_ff;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cap_s1_ff <= 1'b0;
            cap_s2_ff <= 1'b0;
            cap_prev_ff <= 1'b0;
            cap_cnt_ff <= 4'h0;
        end else if (clk_en) begin
            cap_s1_ff <= cap_pin_in;
            cap_s2_ff <= cap_s1_ff;
            cap_prev_ff <= cap_s2_ff;
            if (msel == M_OFF) begin
                cap_cnt_ff <= 4'h0;
            end else if (rise) begin
                cap_cnt_ff <= cap_cnt_ff + 4'h1;
            end
        end
    end
    always_comb begin
        case (msel)
            M_CFALL: cap_evt = fall;
            M_CRISE: cap_evt = rise;
            M_CR4: cap_evt = rise && (cap_cnt_ff[1:0] == 2'h3);
            M_CR16: cap_evt = rise && (cap_cnt_ff == 4'hF);
            default: cap_evt = 1'b0;
        endcase
    end

    // compare match against the external 16-bit timer
    assign cmp_evt = (msel == M_TOG || msel[3:2] == 2'b10)
        && (ext_timer_val == {latch_ff, cmph_ff});

    // ------------------------------------------------------------
    // output pin; level held when nothing matches RULE3 RULE5
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst || (clk_en && msel == M_OFF)) begin
            out_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else if (clk_en) begin
            trig_ff <= cmp_evt && msel == M_CTRG && !trig_ff; // RULE12
            if (pwm_mode) begin
                if (step && tcnt_ff == period_ff) begin
                    out_ff <= (duty_ff != 8'h00) || (mode_ff[5:4] != 2'h0); // RULE14 RULE17
                end else if (base_match) begin
                    out_ff <= 1'b0; // RULE15
                end
            end else if (cmp_evt) begin
                case (msel)
                    M_TOG: out_ff <= !out_ff; // RULE12
                    M_CSET: out_ff <= 1'b1;
                    M_CCLR: out_ff <= 1'b0;
                    default: ;
                endcase
            end
        end
    end
    assign pin_out = out_ff;
    assign pin_oe_n = dir_ff; // reset leaves pin as input RULE8
    assign special_trigger = trig_ff;

    // ------------------------------------------------------------
    // interrupt status: set wins over write-one-to-clear
    // ------------------------------------------------------------
    always_comb begin
        nxt_ist = ist_ff;
        if (bus_req.wr && bus_req.addr == ADR_IST) begin
            nxt_ist = ist_ff & ~bus_req.wdata;
        end
        if (cap_evt || (cmp_evt && !pwm_mode && msel != M_TOG)) begin
            nxt_ist[IRQ_EVT] = 1'b1; // RULE12
        end
        if (period_match && pwm_mode) begin
            nxt_ist[IRQ_PER] = 1'b1;
        end
        if (cmp_evt && msel == M_CTRG) begin
            nxt_ist[IRQ_TRIG] = 1'b1;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ist_ff <= RST_ZERO;
        end else if (clk_en) begin
            ist_ff <= nxt_ist & 8'h07;
        end
    end
    assign irq = |(ist_ff & imsk_ff);

    // ------------------------------------------------------------
    // read port, data valid the cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= RST_ZERO;
        end else if (clk_en) begin
            case (bus_req.addr)
                ADR_MODE: rdata_ff <= mode_ff;
                ADR_DUTY: rdata_ff <= duty_ff;
                ADR_LATCH: rdata_ff <= latch_ff;
                ADR_PERIOD: rdata_ff <= period_ff;
                ADR_TCFG: rdata_ff <= tcfg_ff;
                ADR_TCNT: rdata_ff <= tcnt_ff;
                ADR_CMPH: rdata_ff <= pwm_mode ? cmph_ff : cap_lo_ff;
                ADR_DIR: rdata_ff <= {7'h00, dir_ff};
                ADR_IST: rdata_ff <= ist_ff;
                ADR_IMSK: rdata_ff <= imsk_ff;
                default: rdata_ff <= RST_ZERO; // unmapped reads zero
            endcase
        end
    end
    assign rdata = rdata_ff;
endmodule

// file: bench/cpw_unit_props.sv
`timescale 1ns/10ps
module cpw_unit_props (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire cpw_pkg::cpw_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic cap_pin_in,
    input wire logic [15:0] ext_timer_val,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic special_trigger,
    input wire logic irq
);
    import cpw_pkg::*;
    // ------------------------------------------------------------
    // shadows of accepted writes
    // ------------------------------------------------------------
    logic [7:0] mode_ff, per_ff, msk_ff;
    logic wr_en;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    assign wr_en = bus_req.wr & clk_en;
    // writes in sleep are not taken, so the shadow ignores them too
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_ff <= RST_MODE;
            per_ff <= RST_PERIOD;
            msk_ff <= RST_ZERO;
        end else if (wr_en) begin
            if (bus_req.addr == ADR_MODE) mode_ff <= bus_req.wdata;
            if (bus_req.addr == ADR_PERIOD) per_ff <= bus_req.wdata;
            if (bus_req.addr == ADR_IMSK) msk_ff <= bus_req.wdata;
        end
    end
    AST_RST: assert property (disable iff (1'b0) srst |=> !pin_out && pin_oe_n
        && !irq && !special_trigger && rdata == 8'h00)
        else $error("outputs not at reset level");
    AST_SLEEP: assert property (!clk_en |=> $stable(pin_out) && $stable(pin_oe_n)
        && $stable(rdata) && $stable(irq))
        else $error("state moved during sleep");
    AST_TRIG: assert property (special_trigger |-> mode_ff[3:0] == M_CTRG
        || $past(mode_ff[3:0]) == M_CTRG)
        else $error("trigger outside trigger mode");
    AST_OFF: assert property (mode_ff[3:0] == M_OFF && clk_en |=> !pin_out)
        else $error("output high while unit off");
    AST_IRQ: assert property ($past(msk_ff) == 8'h00 && msk_ff == 8'h00 |-> !irq)
        else $error("irq with all sources masked");
    AST_DIR: assert property (wr_en && bus_req.addr == ADR_DIR && !bus_req.wdata[0]
        ##1 (clk_en && !bus_req.wr)[*2] |-> !pin_oe_n)
        else $error("pin not driven after direction write");
    AST_RD_MODE: assert property (bus_req.rd && clk_en && bus_req.addr == ADR_MODE
        |=> rdata == {2'h0, $past(mode_ff[5:0])})
        else $error("mode read back wrong");
    AST_RD_PER: assert property (bus_req.rd && clk_en && bus_req.addr == ADR_PERIOD
        |=> rdata == $past(per_ff))
        else $error("period read back wrong");
endmodule

bind cpw_unit cpw_unit_props u_props (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en),
    .bus_req(bus_req), .rdata(rdata), .cap_pin_in(cap_pin_in), .ext_timer_val(ext_timer_val),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .special_trigger(special_trigger), .irq(irq));

// file: bench/cpw_load.sv
`timescale 1ns/10ps
module cpw_load (
    input wire logic clk_sys,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    output logic [15:0] high_len,
    output logic [15:0] period_len,
    output logic [15:0] rises,
    output logic [15:0] falls
);
    // ------------------------------------------------------------
    // load with pull-down, measures each pulse
    // ------------------------------------------------------------
    logic lvl;
    logic lvl_ff = 1'b0;
    logic [15:0] hi_ff = 16'h0000;
    logic [15:0] run_ff = 16'h0000;
    // a released pin reads low, never the last driven level
    assign lvl = pin_out & ~pin_oe_n;
    initial begin
        {high_len, period_len, rises, falls} = 64'h0;
    end
    // period runs rise to rise; high time counted inside it
    always @(posedge clk_sys) begin
        lvl_ff <= lvl;
        if (!lvl && lvl_ff) falls <= falls + 16'h1;
        if (lvl && !lvl_ff) begin
            period_len <= run_ff;
            high_len <= hi_ff;
            run_ff <= 16'h1;
            hi_ff <= 16'h1;
            rises <= rises + 16'h1;
        end else begin
            run_ff <= run_ff + 16'h1;
            hi_ff <= hi_ff + {15'h0, lvl};
        end
    end
endmodule

// file: bench/tb_cpw_unit.sv
`timescale 1ns/10ps
module tb_cpw_unit;
    import cpw_pkg::*;
    // ------------------------------------------------------------
    // stimulus, tasks and tests
    // ------------------------------------------------------------
    logic clk_sys = 1'b0, srst = 1'b1, clk_en = 1'b1, cap = 1'b0, pin_out, pin_oe_n, trig, irq;
    cpw_bus_req_t req = '0;
    logic [15:0] ext = 16'h0000, hi_len, per_len, rises, falls, r;
    logic [7:0] rdata;
    logic [9:0] dt [3] = '{10'd6, 10'd1, 10'd15};
    logic [3:0] cm [5] = '{M_CSET, M_CCLR, M_TOG, M_CSWI, M_CTRG};
    int err_count = 0, samples_checked = 0, trig_n = 0;
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (trig === 1'b1) trig_n <= trig_n + 1;
    cpw_unit uut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .bus_req(req), .rdata(rdata),
        .cap_pin_in(cap), .ext_timer_val(ext), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .special_trigger(trig), .irq(irq));
    cpw_load u_load (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .high_len(hi_len), .period_len(per_len), .rises(rises), .falls(falls));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one idle cycle after each access keeps strobes to one assignment per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        @(negedge clk_sys);
        chk({8'h00, rdata}, {8'h00, e});
        @(posedge clk_sys);
    endtask
    task automatic pwm(input logic [9:0] d, input logic [1:0] ps);
        wr(ADR_DUTY, d[9:2]);
        wr(ADR_MODE, {2'h0, d[1:0], 4'hC});
        wr(ADR_TCFG, {5'h00, 1'b1, ps});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // bounded wait for the next rising edge seen by the load
    task automatic wait_rise;
        @(negedge clk_sys);
        r = rises;
        for (int i = 0; i < 2000 && rises === r; i++) @(negedge clk_sys);
        if (rises === r) begin
            err_count++;
            finish_test();
        end
        @(posedge clk_sys);
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #500000;
        err_count++;
        finish_test();
    end
    initial begin
        cyc(8);
        srst <= 1'b0;
        chk(16'(pin_oe_n), 16'h0001);
        rd(ADR_MODE, RST_MODE);
        rd(ADR_PERIOD, RST_PERIOD);
        rd(ADR_TCNT, RST_ZERO);
        rd(ADR_DIR, 8'h01);
        rd(4'hF, RST_ZERO);
        wr(ADR_MODE, 8'hFF);
        rd(ADR_MODE, 8'h3F);
        $display("test reset done");
        wr(ADR_PERIOD, 8'h03);
        wr(ADR_DIR, 8'h00);
        for (int i = 0; i < 3; i++) begin
            pwm(dt[i], i[1:0]);
            repeat (3) wait_rise();
            chk(per_len, 16'(16 << (2 * i)));
            chk(hi_len, 16'(dt[i] << (2 * i)));
        end
        wr(ADR_LATCH, 8'hAA);
        rd(ADR_LATCH, 8'h03);
        $display("test pwm done");
        pwm(10'd6, PS_DIV1);
        repeat (2) wait_rise();
        clk_en <= 1'b0;
        cyc(50);
        clk_en <= 1'b1;
        wait_rise();
        chk(per_len, 16'h0042);
        chk(hi_len, 16'h0038);
        $display("test sleep done");
        pwm(10'd0, PS_DIV1);
        cyc(40);
        r = rises;
        cyc(40);
        chk(rises, r);
        pwm(10'd16, PS_DIV1);
        cyc(40);
        r = falls;
        cyc(60);
        chk(falls, r);
        chk(16'(pin_out), 16'h0001);
        wr(ADR_MODE, {4'h0, M_OFF});
        cyc(4);
        chk(16'(pin_out), 16'h0000);
        $display("test duty limits done");
        wr(ADR_TCFG, RST_TCFG);
        wr(ADR_IMSK, 8'h05);
        foreach (cm[i]) begin
            wr(ADR_MODE, {4'h0, M_OFF});
            wr(ADR_IST, 8'h07);
            wr(ADR_CMPH, 8'h34);
            wr(ADR_MODE, {4'h0, cm[i]});
            wr(ADR_LATCH, 8'h12); // mode off clears the latch, so write it after
            ext <= 16'h1234;
            cyc(1);
            ext <= 16'h0000;
            cyc(4);
            chk(16'(pin_out), 16'(cm[i] inside {M_CSET, M_TOG}));
            chk(16'(irq), 16'(cm[i] != M_TOG));
            rd(ADR_IST, {5'h00, cm[i] == M_CTRG, 1'b0, cm[i] != M_TOG});
        end
        chk(16'(trig_n), 16'h0001);
        wr(ADR_IMSK, 8'h00);
        cyc(2);
        chk(16'(irq), 16'h0000);
        wr(ADR_IST, 8'h07);
        rd(ADR_IST, 8'h00);
        $display("test compare done");
        // five rising edges: only the fourth may capture
        wr(ADR_MODE, {4'h0, M_CR4});
        for (int i = 1; i < 6; i++) begin
            ext <= {8'hC0, 8'(i)};
            cap <= 1'b1;
            cyc(4);
            cap <= 1'b0;
            cyc(4);
        end
        rd(ADR_LATCH, 8'hC0);
        rd(ADR_CMPH, 8'h04);
        $display("test capture done");
        finish_test();
    end
endmodule
